// ===== hw/plsel_pkg.sv
// package: offsets, field codes and reset values of the pin function selector
package plsel_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int REG_W = 16;
   localparam int SP_PINS = 8;
   localparam int PL_PINS = 8;
   localparam int CHANS = 3;
   localparam int SYNC_STAGES = 3;
   localparam logic [11:0] ADDR_PORT_L = 12'h000;
   localparam logic [11:0] ADDR_SERIAL = 12'h004;
   localparam logic [15:0] PORT_L_RESET = 16'h0000;
   localparam logic [15:0] SERIAL_RESET = 16'hA888;
   localparam logic [1:0] FLD_PERIPH = 2'h0;
   localparam logic [1:0] FLD_OUT = 2'h1;
   localparam logic [1:0] FLD_IN_PU = 2'h2;
   localparam logic [1:0] FLD_IN = 2'h3;
   // serial fields that cover a transmit/receive pair
   localparam logic [7:0] CHAN_MASK = 8'h15;
   // serial field with no general output code
   localparam logic [7:0] NO_OUT_MASK = 8'h80;
   localparam logic [31:0] ZERO_WORD = 32'h00000000;
endpackage : plsel_pkg

// ===== hw/plsel_top.sv
// pin function selector for port L and the serial pin group, APB register access
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
module plsel_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [2:0] tx_on_bit,
   input wire logic [2:0] rx_on_bit,
   input wire logic [2:0] sci_txd,
   output logic [2:0] sci_rxd,
   input wire logic [7:0] periph_out,
   input wire logic [7:0] periph_oe,
   input wire logic [7:0] serial_pin_gpio_bit,
   output logic [7:0] sp_rd_data,
   input wire logic [7:0] sp_pad_in,
   output logic [7:0] sp_pad_out,
   output logic [7:0] sp_pad_oe,
   output logic [7:0] sp_pad_pu,
   output logic [7:0] sp_pad_periph,
   input wire logic [2:0] rx_pad_in,
   output logic [2:0] rx_pad_pu,
   output logic [2:0] rx_pad_periph,
   output logic [7:0] pl_pad_periph,
   output logic [7:0] pl_pad_input
);
   logic [15:0] port_l_function_select_q;
   logic [15:0] port_l_function_select_d;
   logic [15:0] serial_pin_function_select_q;
   logic [15:0] serial_pin_function_select_d;
   logic pready_q;
   logic pready_d;
   logic pslverr_q;
   logic pslverr_d;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic access;
   logic hit_pl;
   logic hit_sp;
   logic [10:0] s1_q;
   logic [10:0] s2_q;
   logic [10:0] s3_q;
   logic [10:0] s1_d;
   logic [10:0] s2_d;
   logic [10:0] s3_d;
   logic [10:0] stab_q;
   logic [10:0] stab_d;
   logic [10:0] diff;
   logic [7:0] sp_out_d;
   logic [7:0] sp_oe_d;
   logic [7:0] sp_pu_d;
   logic [7:0] sp_per_d;
   logic [7:0] sp_rd_d;
   logic [2:0] rx_pu_d;
   logic [2:0] rx_per_d;
   logic [2:0] rxd_d;
   logic [7:0] pl_per_d;
   logic [7:0] pl_in_d;
   logic [7:0] sp_out_q;
   logic [7:0] sp_oe_q;
   logic [7:0] sp_pu_q;
   logic [7:0] sp_per_q;
   logic [7:0] sp_rd_q;
   logic [2:0] rx_pu_q;
   logic [2:0] rx_per_q;
   logic [2:0] rxd_q;
   logic [7:0] pl_per_q;
   logic [7:0] pl_in_q;

   assign access = psel & penable;
   assign hit_pl = (paddr == plsel_pkg::ADDR_PORT_L);
   assign hit_sp = (paddr == plsel_pkg::ADDR_SERIAL);

   // apb slave: one wait cycle, write at the acknowledging edge
   always_comb begin
      port_l_function_select_d = port_l_function_select_q;
      serial_pin_function_select_d = serial_pin_function_select_q;
      pready_d = access & ~pready_q;
      pslverr_d = access & ~pready_q & ~hit_pl & ~hit_sp;
      prdata_d = plsel_pkg::ZERO_WORD;
      if (access & ~pready_q & ~pwrite) begin
         if (hit_pl) begin
            prdata_d = {16'h0000, port_l_function_select_q};
         end else if (hit_sp) begin
            prdata_d = {16'h0000, serial_pin_function_select_q};
         end
      end
      if (access & pready_q & pwrite) begin
         if (hit_pl) begin
            if (pstrb[0]) begin
               port_l_function_select_d[7:0] = pwdata[7:0];
            end
            if (pstrb[1]) begin
               port_l_function_select_d[15:8] = pwdata[15:8];
            end
         end else if (hit_sp) begin
            if (pstrb[0]) begin
               serial_pin_function_select_d[7:0] = pwdata[7:0];
            end
            if (pstrb[1]) begin
               serial_pin_function_select_d[15:8] = pwdata[15:8];
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_l_function_select_q <= plsel_pkg::PORT_L_RESET;
         serial_pin_function_select_q <= plsel_pkg::SERIAL_RESET;
         pready_q <= 1'h0;
         pslverr_q <= 1'h0;
         prdata_q <= plsel_pkg::ZERO_WORD;
      end else begin
         port_l_function_select_q <= port_l_function_select_d;
         serial_pin_function_select_q <= serial_pin_function_select_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q <= prdata_d;
      end
   end

   // pad inputs: three stages, a change counts once stages two and three agree
   assign diff = s2_q ^ s3_q;
   always_comb begin
      s1_d = {rx_pad_in, sp_pad_in};
      s2_d = s1_q;
      s3_d = s2_q;
      stab_d = (s2_q & ~diff) | (stab_q & diff);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= 11'h000;
         s2_q <= 11'h000;
         s3_q <= 11'h000;
         stab_q <= 11'h000;
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
         stab_q <= stab_d;
      end
   end

   genvar i;
   generate
      for (i = 0; i < plsel_pkg::PL_PINS; i++) begin : g_pl
         logic [1:0] fl;
         assign fl = port_l_function_select_q[2*i+1:2*i];
         assign pl_per_d[i] = (fl == plsel_pkg::FLD_PERIPH);
         assign pl_in_d[i] = fl[1];
      end
      for (i = 0; i < plsel_pkg::SP_PINS; i++) begin : g_sp
         logic [1:0] f;
         assign f = serial_pin_function_select_q[2*i+1:2*i];
         if (plsel_pkg::CHAN_MASK[i]) begin : g_chan
            localparam int C = i / 2;
            logic te;
            logic re;
            logic tx_out;
            logic tx_per;
            logic rx_per;
            logic rx_pu;
            assign te = tx_on_bit[C];
            assign re = rx_on_bit[C];
            always_comb begin
               tx_out = 1'h0;
               tx_per = 1'h0;
               rx_per = 1'h0;
               rx_pu = 1'h0;
               case (f)
                  plsel_pkg::FLD_PERIPH: begin
                     tx_per = 1'h1;
                     rx_per = 1'h1;
                  end
                  plsel_pkg::FLD_OUT: begin
                     tx_out = 1'h1;
                     rx_per = 1'h1;
                  end
                  plsel_pkg::FLD_IN_PU: begin
                     rx_pu = 1'h1;
                  end
                  default: begin
                     rx_pu = 1'h0;
                  end
               endcase
            end
            // input codes float transmit pin when disabled
            assign sp_oe_d[i] = te | tx_out;
            assign sp_out_d[i] = te ? sci_txd[C] : serial_pin_gpio_bit[i];
            assign sp_per_d[i] = te | tx_per;
            assign sp_pu_d[i] = 1'h0;
            assign rx_per_d[C] = re | rx_per;
            assign rx_pu_d[C] = rx_pu;
            assign rxd_d[C] = stab_q[8+C];
            assign sp_rd_d[i] = tx_out ? serial_pin_gpio_bit[i] : stab_q[8+C];
         end else begin : g_gen
            logic outsel;
            logic per_g;
            logic pu_g;
            // pin 7 has no output code
            always_comb begin
               outsel = 1'h0;
               per_g = 1'h0;
               pu_g = 1'h0;
               case (f)
                  plsel_pkg::FLD_PERIPH: begin
                     per_g = 1'h1;
                  end
                  plsel_pkg::FLD_OUT: begin
                     outsel = ~plsel_pkg::NO_OUT_MASK[i];
                  end
                  plsel_pkg::FLD_IN_PU: begin
                     pu_g = 1'h1;
                  end
                  default: begin
                     pu_g = 1'h0;
                  end
               endcase
            end
            assign sp_oe_d[i] = per_g ? periph_oe[i] : outsel;
            assign sp_out_d[i] = per_g ? periph_out[i] : serial_pin_gpio_bit[i];
            assign sp_per_d[i] = per_g;
            assign sp_pu_d[i] = pu_g;
            assign sp_rd_d[i] = outsel ? serial_pin_gpio_bit[i] : stab_q[i];
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp_out_q <= 8'h00;
         sp_oe_q <= 8'h00;
         sp_pu_q <= 8'h00;
         sp_per_q <= 8'h00;
         sp_rd_q <= 8'h00;
         rx_pu_q <= 3'h0;
         rx_per_q <= 3'h0;
         rxd_q <= 3'h0;
         pl_per_q <= 8'h00;
         pl_in_q <= 8'h00;
      end else begin
         sp_out_q <= sp_out_d;
         sp_oe_q <= sp_oe_d;
         sp_pu_q <= sp_pu_d;
         sp_per_q <= sp_per_d;
         sp_rd_q <= sp_rd_d;
         rx_pu_q <= rx_pu_d;
         rx_per_q <= rx_per_d;
         rxd_q <= rxd_d;
         pl_per_q <= pl_per_d;
         pl_in_q <= pl_in_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign sci_rxd = rxd_q;
   assign sp_rd_data = sp_rd_q;
   assign sp_pad_out = sp_out_q;
   assign sp_pad_oe = sp_oe_q;
   assign sp_pad_pu = sp_pu_q;
   assign sp_pad_periph = sp_per_q;
   assign rx_pad_pu = rx_pu_q;
   assign rx_pad_periph = rx_per_q;
   assign pl_pad_periph = pl_per_q;
   assign pl_pad_input = pl_in_q;
endmodule : plsel_top

// ===== verif/plsel_chk.sv
// checker: port relations of the pin function selector
`timescale 1ns/1ns
module plsel_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [2:0] tx_on_bit,
   input wire logic [2:0] rx_on_bit,
   input wire logic [2:0] sci_txd,
   input wire logic [7:0] sp_pad_out,
   input wire logic [7:0] sp_pad_oe,
   input wire logic [7:0] sp_pad_pu,
   input wire logic [7:0] sp_pad_periph,
   input wire logic [2:0] rx_pad_pu,
   input wire logic [2:0] rx_pad_periph,
   input wire logic [7:0] pl_pad_periph,
   input wire logic [7:0] pl_pad_input
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_tx_force: assert property (tx_on_bit[1] |=> sp_pad_oe[2] && sp_pad_out[2] == $past(sci_txd[1]))
      else $error("transmit pad not given to the serial output");
   a_rx_input: assert property (rx_on_bit[0] |=> rx_pad_periph[0])
      else $error("receive pad not given to the serial input");
   a_pl_excl: assert property ((pl_pad_periph & pl_pad_input) == 8'h00)
      else $error("port pin both peripheral and input");
   a_pin7_hold: assert property (sp_pad_oe[7] |-> sp_pad_periph[7])
      else $error("pin 7 driven outside peripheral function");
   a_pu_no_drive: assert property ((sp_pad_pu & sp_pad_oe & 8'hEA) == 8'h00)
      else $error("pulled-up pin also driven");
   a_tx_hiz: assert property (rx_pad_pu[0] && !$past(tx_on_bit[0]) |-> !sp_pad_oe[0])
      else $error("input code with transmit off still drives");
   a_reset_load: assert property ($rose(presetn) |=> (sp_pad_pu & 8'hEA) == 8'hEA && pl_pad_periph == 8'hFF)
      else $error("pads not decoded from reset values");
   a_err_map: assert property (pready |-> pslverr == (paddr != plsel_pkg::ADDR_PORT_L && paddr != plsel_pkg::ADDR_SERIAL))
      else $error("slave error does not match address map");
endmodule : plsel_chk
bind plsel_top plsel_chk plsel_chk_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .pready(pready),
   .pslverr(pslverr), .tx_on_bit(tx_on_bit), .rx_on_bit(rx_on_bit), .sci_txd(sci_txd), .sp_pad_out(sp_pad_out),
   .sp_pad_oe(sp_pad_oe), .sp_pad_pu(sp_pad_pu), .sp_pad_periph(sp_pad_periph), .rx_pad_pu(rx_pad_pu),
   .rx_pad_periph(rx_pad_periph), .pl_pad_periph(pl_pad_periph), .pl_pad_input(pl_pad_input));

// ===== verif/plsel_pads.sv
// partner: pad levels seen by the selector
`timescale 1ns/1ns
module plsel_pads (
   input wire logic pclk,
   input wire logic [7:0] sp_pad_out,
   input wire logic [7:0] sp_pad_oe,
   input wire logic [7:0] sp_pad_pu,
   input wire logic [2:0] rx_pad_pu,
   input wire logic ext_en,
   input wire logic [7:0] ext_val,
   output logic [7:0] sp_pad_in,
   output logic [2:0] rx_pad_in
);
   logic [7:0] flip_q = 8'h5A;
   always @(posedge pclk) begin
      flip_q <= ~flip_q;
   end
   // level: own drive, outside drive, pull-up, else wandering
   always_comb begin
      for (int b = 0; b < 8; b++) begin
         sp_pad_in[b] = sp_pad_oe[b] ? sp_pad_out[b] : ext_en ? ext_val[b] : sp_pad_pu[b] ? 1'b1 : flip_q[b];
      end
      for (int k = 0; k < 3; k++) begin
         rx_pad_in[k] = ext_en ? ext_val[k] : rx_pad_pu[k] ? 1'b1 : flip_q[k];
      end
   end
endmodule : plsel_pads

// ===== verif/tb_top.sv
// testbench: register access and pad decode against a behavioural model
`timescale 1ns/1ns
module tb_top;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ext_en = 1'b0, pready, pslverr, er, ch, lv;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata, rd, seed = 32'h00001736;
   logic [2:0] tx = 3'h0, rx = 3'h0, stx = 3'h0, sci_rxd, rx_pad_in, rx_pad_pu, rx_pad_periph;
   logic [7:0] po = 8'h00, poe = 8'h00, gp = 8'h00, ev = 8'h00, eoe, eout, erd, rdm, eper;
   logic [3:0] strb = 4'hF;
   logic [7:0] sp_pad_in, sp_rd_data, sp_pad_out, sp_pad_oe, sp_pad_pu, sp_pad_periph, pl_pad_periph, pl_pad_input;
   int err_count = 0, checks = 0, cyc = 0;
   int rm[$];
   initial forever #2 pclk = ~pclk;
   plsel_top plsel_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tx_on_bit(tx), .rx_on_bit(rx), .sci_txd(stx), .sci_rxd(sci_rxd), .periph_out(po), .periph_oe(poe),
      .serial_pin_gpio_bit(gp), .sp_rd_data(sp_rd_data), .sp_pad_in(sp_pad_in), .sp_pad_out(sp_pad_out),
      .sp_pad_oe(sp_pad_oe), .sp_pad_pu(sp_pad_pu), .sp_pad_periph(sp_pad_periph), .rx_pad_in(rx_pad_in),
      .rx_pad_pu(rx_pad_pu), .rx_pad_periph(rx_pad_periph), .pl_pad_periph(pl_pad_periph), .pl_pad_input(pl_pad_input));
   plsel_pads plsel_pads_i (.pclk(pclk), .sp_pad_out(sp_pad_out), .sp_pad_oe(sp_pad_oe), .sp_pad_pu(sp_pad_pu),
      .rx_pad_pu(rx_pad_pu), .ext_en(ext_en), .ext_val(ev), .sp_pad_in(sp_pad_in), .rx_pad_in(rx_pad_in));
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
      checks++;
      if (seen !== ex) begin
         $display("ERROR %s expected %h seen %h", nm, ex, seen);
         err_count++;
      end
   endtask : chk
   task test_done();
      $display("comparisons %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : test_done
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      logic [31:0] m;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      if (n >= 20) begin
         $display("ERROR pready expected 1 seen %b", pready);
         err_count++;
      end
      m = {16'h0000, {8{strb[1]}}, {8{strb[0]}}};
      if (w && a < 12'h008) rm[a[2]] = (rm[a[2]] & ~m) | (d & m);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task rdchk(input logic [11:0] a);
      apb(1'b0, a, 32'h00000000);
      chk("read data", rd, a < 12'h008 ? rm[a[2]] : 0);
      chk("slave error", 32'(er), 32'(a >= 12'h008));
   endtask : rdchk
   task do_reset();
      presetn <= 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rm = '{0, 32'h0000A888};
      @(posedge pclk);
   endtask : do_reset
   always @(posedge pclk) begin
      cyc++;
      if (cyc > 5000) begin
         $display("ERROR cycle limit expected %0d seen %0d", 5000, cyc);
         err_count++;
         test_done();
      end
   end
   initial begin
      do_reset();
      apb(1'b1, 12'h00C, rnd());
      for (int a = 0; a < 16; a += 4) rdchk(12'(a));
      $display("test reset values done");
      // analog outputs unused here, so port L may change
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, 12'h000, {8{2'(c)}} | (rnd() & 32'hFFFF0000));
         repeat (2) @(posedge pclk);
         chk("port periph", pl_pad_periph, c == 0 ? 32'hFF : 32'h0);
         chk("port input", pl_pad_input, c >= 2 ? 32'hFF : 32'h0);
         rdchk(12'h000);
      end
      $display("test port decode done");
      for (int c = 0; c < 4; c++) for (int t = 0; t < 2; t++) begin
         tx <= t ? 3'h7 : 3'h0;
         rx <= t ? 3'h0 : 3'h7;
         stx <= 3'(rnd());
         gp <= 8'(rnd());
         po <= 8'(rnd());
         poe <= 8'(rnd()) | 8'h80;
         ev <= 8'(rnd());
         ext_en <= c == 3;
         apb(1'b1, 12'h004, {8{2'(c)}});
         repeat (8) @(posedge pclk);
         for (int b = 0; b < 8; b++) begin
            ch = b % 2 == 0 && b < 6;
            lv = c == 2 ? 1'b1 : ev[ch ? b / 2 : b];
            eoe[b] = ch ? (t == 1 || c == 1) : (c == 1 && b != 7) || (c == 0 && poe[b]);
            eout[b] = ch ? (t == 1 ? stx[b / 2] : gp[b]) : (c == 0 ? po[b] : gp[b]);
            erd[b] = c == 1 && b != 7 ? gp[b] : lv;
            rdm[b] = c != 0 && !(c == 1 && b == 7);
            eper[b] = ch ? (t == 1 || c == 0) : c == 0;
         end
         chk("pad enable", sp_pad_oe, eoe);
         chk("pad out", sp_pad_out & eoe, eout & eoe);
         chk("pad pull", sp_pad_pu, {8{c == 2}} & 8'hEA);
         chk("pad periph", sp_pad_periph, eper);
         chk("readback", sp_rd_data & rdm, erd & rdm);
         chk("rx periph", rx_pad_periph, rx | {3{c < 2}});
         chk("rx pull", rx_pad_pu, {3{c == 2}});
         if (t == 0 && c >= 2) chk("rx level", sci_rxd, c == 2 ? 3'h7 : ev[2:0]);
      end
      $display("test serial decode done");
      strb <= 4'h2;
      apb(1'b1, 12'h000, 32'h00005555);
      rdchk(12'h000);
      strb <= 4'hF;
      do_reset();
      rdchk(12'h000);
      rdchk(12'h004);
      $display("test second reset done");
      test_done();
   end
endmodule : tb_top
